//--- hdl/clock_manager_defines.svh
// Offsets, reset values and timing counts of the clock manager block.
// Assumes a 32-bit register port with byte offsets in 8-bit addresses.
`ifndef CLOCK_MANAGER_DEFINES_SVH
`define CLOCK_MANAGER_DEFINES_SVH

`define ADDR_CTRL        8'h00
`define ADDR_RATIO       8'h04
`define ADDR_HINT        8'h08
`define ADDR_PHASE       8'h0c
`define ADDR_JITTER      8'h10
`define ADDR_STATUS      8'h14

`define CTRL_W           13
`define RATIO_W          22
`define HINT_W           16
`define PHASE_W          11
`define JITTER_W         16

`define RST_HALVES       6'h04
`define RST_MULT         6'h04
`define RST_DIVISOR      6'h01
`define RST_HINT         16'h0000
`define RST_PHASE        11'h000
`define RST_JITTER       16'hf0f0
`define RST_LOCK_CYCLE   3'h5

`define HALVES_MIN       6'h03
`define HALVES_INT_FROM  6'h10
`define HALVES_MAX       6'h20
`define MULT_MIN         6'h02
`define MULT_MAX         6'h20
`define DIVISOR_MIN      6'h01
`define DIVISOR_MAX      6'h20

`define PHASE_POS_MAX    11'sh0ff
`define PHASE_NEG_MIN    11'sh701
`define PHASE_DIRECT_MAX 11'sh3ff
`define PHASE_SPEED_LIM  11'sh07f
`define PHASE_FRAC_BITS  8
`define HINT_FRAC_BITS   8

`define CLK_PERIOD_NS    16'h000a
`define LOCK_PERIODS     4'h8
`define DESKEW_SYS_CYC   16'sh0002
`define LOOP_LO_MIN_PER  12'h008
`define LOOP_HI_MAX_PER  12'h010
`define LOOP_HI_MIN_PER  12'h002
`define SYNTH_LO_MIN_PER 12'h006
`define SYNTH_HI_MAX_PER 12'h020
`define HINT_TOL         12'h001

`endif

//--- hdl/clock_manager_pkg.sv
// Types of the clock manager block: configuration words, status, ports.
// Assumes clock_manager_defines.svh for widths and values.
`include "clock_manager_defines.svh"

package clock_manager_pkg;

   typedef enum logic [2:0] {
      SHIFT_NONE     = 3'h0,
      SHIFT_FIXED    = 3'h1,
      SHIFT_VAR_POS  = 3'h2,
      SHIFT_VAR_CTR  = 3'h3,
      SHIFT_DIRECT   = 3'h4
   } phase_shift_mode_t;

   typedef enum logic [1:0] {
      LOCK_SEARCH = 2'h0,
      LOCK_TRACK  = 2'h1,
      LOCK_DONE   = 2'h3
   } lock_state_t;

   typedef struct packed {
      logic [2:0]        lock_wait_cycle;
      logic              startup_wait;
      logic              max_range;
      logic              duty_correct;
      logic              loop_high;
      logic              synth_high;
      logic              source_sync;
      phase_shift_mode_t phase_shift_mode;
      logic              input_halve_enable;
   } ctrl_t;

   typedef struct packed {
      logic [5:0] synth_divisor;
      logic [1:0] pad1;
      logic [5:0] synth_multiplier;
      logic [1:0] pad0;
      logic [5:0] divided_clock_ratio;
   } ratio_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wr_data;
      logic        wr_en;
      logic        rd_en;
   } bus_req_t;

   typedef struct packed {
      logic phase_0_out;
      logic phase_90_out;
      logic phase_180_out;
      logic phase_270_out;
      logic divided_clock_out;
      logic synth_clock_out;
      logic synth_clock_out_inverted;
   } clk_out_t;

   typedef struct packed {
      ctrl_t                      ctrl;
      ratio_t                     ratio;
      logic [`HINT_W-1:0]         input_period_hint;
      logic signed [`PHASE_W-1:0] phase_cfg;
      logic [`JITTER_W-1:0]       jitter_filter_setting;
      logic signed [`PHASE_W-1:0] phase_cur;
      logic                       src_q;
      logic                       tog;
      logic [11:0]                pos;
      logic [11:0]                per;
      logic [11:0]                hi;
      logic [11:0]                hi_cnt;
      logic [3:0]                 stable;
      lock_state_t                lock;
      logic [16:0]                dv;
      logic [17:0]                fx;
      clk_out_t                   outs;
      logic [31:0]                rdata;
   } state_t;

endpackage : clock_manager_pkg

//--- hdl/clock_manager.sv
// Clock manager: measures the source clock on the reference clock and
// rebuilds the 1x phases, divided and synthesized clocks digitally.
// Assumes source_clock_in_i and all bus signals are synchronous to ref_clk_i.
// How it works
// - Startup stalls in chosen cycle until locked
// - Divided output is source over N/2
// - Divided duty 50/50 except fractional high mode
// - Optional halving of the source clock
// - Period hint in ns gates synth outputs
// - Five phase shift modes, default none
// - Feedback delay system or source synchronous
// - Synthesizer low or high frequency range
// - Loop low or high frequency range
// - Duty correction gives 50/50 phase outputs
// - Priority selects speed or wide phase range
// - Signed phase offset clamped per mode
// - Synth output is input times M over D
// - Variable steps move one 256th period
`timescale 1ns/1ps
`include "clock_manager_defines.svh"

module clock_manager (
   input  wire logic                      ref_clk_i,
   input  wire logic                      reset_n_i,
   input  wire logic                      clk_en_i,
   input  wire clock_manager_pkg::bus_req_t bus_i,
   output logic [31:0]                    rd_data_o,
   input  wire logic                      source_clock_in_i,
   input  wire logic                      shift_step_enable_i,
   input  wire logic                      shift_direction_i,
   input  wire logic [2:0]                startup_cycle_i,
   output logic                           startup_stall_o,
   output logic                           locked_o,
   output clock_manager_pkg::clk_out_t    clocks_o
);

   clock_manager_pkg::state_t s;
   clock_manager_pkg::state_t next_s;

   function automatic logic signed [`PHASE_W-1:0] clamp_phase(
      input clock_manager_pkg::phase_shift_mode_t mode,
      input logic                                 max_range,
      input logic signed [`PHASE_W-1:0]           v);
      logic signed [`PHASE_W-1:0] lo;
      logic signed [`PHASE_W-1:0] hi;
      lo = `RST_PHASE;
      hi = `RST_PHASE;
      case (mode)
         clock_manager_pkg::SHIFT_FIXED,
         clock_manager_pkg::SHIFT_VAR_CTR: begin
            lo = `PHASE_NEG_MIN;
            hi = `PHASE_POS_MAX;
         end
         clock_manager_pkg::SHIFT_VAR_POS: hi = `PHASE_POS_MAX;
         // Direct mode always starts at zero; steps then walk taps
         clock_manager_pkg::SHIFT_DIRECT:  hi = `PHASE_DIRECT_MAX;
         default: hi = `RST_PHASE;
      endcase
      // Speed priority narrows the usable phase window
      if (!max_range && mode != clock_manager_pkg::SHIFT_DIRECT) begin
         if (hi > `PHASE_SPEED_LIM) hi = `PHASE_SPEED_LIM;
         if (lo < -`PHASE_SPEED_LIM) lo = -`PHASE_SPEED_LIM;
      end
      if (v < lo)
         clamp_phase = lo;
      else if (v > hi)
         clamp_phase = hi;
      else
         clamp_phase = v;
   endfunction : clamp_phase

   function automatic logic [12:0] wrap(input logic [12:0] v, input logic [11:0] p);
      wrap = (v >= {1'b0, p}) ? v - {1'b0, p} : v;
   endfunction : wrap

   always_comb begin
      clock_manager_pkg::ratio_t     w_ratio;
      clock_manager_pkg::ctrl_t      w_ctrl;
      logic                          raw_rise;
      logic                          eff_rise;
      logic                          eff_lvl;
      logic [11:0]                   meas;
      logic                          in_range;
      logic                          match;
      logic                          locked;
      logic [11:0]                   p;
      logic [11:0]                   half;
      logic signed [23:0]            prod;
      logic signed [15:0]            sh;
      logic [15:0]                   shm;
      logic [12:0]                   ps;
      logic [17:0]                   dv_per;
      logic [17:0]                   dv_hi;
      logic [17:0]                   dv_inc;
      logic [17:0]                   pd;
      logic [18:0]                   fx_sum;
      logic [15:0]                   hint_cyc;
      logic                          hint_ok;
      logic                          synth_ok;
      logic                          var_mode;
      // Defaults keep every local driven on all paths
      raw_rise = 1'b0;
      eff_rise = 1'b0;
      eff_lvl  = 1'b0;
      meas     = '0;
      in_range = 1'b0;
      match    = 1'b0;
      locked   = 1'b0;
      p        = '0;
      half     = '0;
      prod     = '0;
      sh       = '0;
      shm      = '0;
      ps       = '0;
      dv_per   = '0;
      dv_hi    = '0;
      dv_inc   = '0;
      pd       = '0;
      fx_sum   = '0;
      hint_cyc = '0;
      hint_ok  = 1'b0;
      synth_ok = 1'b0;
      var_mode = 1'b0;
      w_ratio  = bus_i.wr_data[`RATIO_W-1:0];
      w_ctrl   = bus_i.wr_data[`CTRL_W-1:0];
      next_s   = s;
      next_s.rdata = '0;

      // Source edge, optional toggle halving
      raw_rise = source_clock_in_i & ~s.src_q;
      next_s.src_q = source_clock_in_i;
      if (raw_rise) next_s.tog = ~s.tog;
      eff_rise = raw_rise & (~s.ctrl.input_halve_enable | ~s.tog);
      eff_lvl  = s.ctrl.input_halve_enable ? s.tog : s.src_q;
      meas     = s.pos + 12'h001;
      in_range = s.ctrl.loop_high ?
                 (meas <= `LOOP_HI_MAX_PER && meas >= `LOOP_HI_MIN_PER) :
                 (meas >= `LOOP_LO_MIN_PER);
      match    = (meas == s.per) || (meas == s.per + 12'h001) ||
                 (meas + 12'h001 == s.per);

      if (eff_rise) begin
         next_s.pos    = '0;
         next_s.per    = meas;
         next_s.hi     = s.hi_cnt;
         next_s.hi_cnt = '0;
         case (s.lock)
            clock_manager_pkg::LOCK_SEARCH: begin
               if (in_range && match) next_s.lock = clock_manager_pkg::LOCK_TRACK;
               next_s.stable = '0;
            end
            clock_manager_pkg::LOCK_TRACK: begin
               if (!(in_range && match))
                  next_s.lock = clock_manager_pkg::LOCK_SEARCH;
               else if (s.stable == `LOCK_PERIODS - 4'h1)
                  next_s.lock = clock_manager_pkg::LOCK_DONE;
               else
                  next_s.stable = s.stable + 4'h1;
            end
            clock_manager_pkg::LOCK_DONE: begin
               if (!(in_range && match)) next_s.lock = clock_manager_pkg::LOCK_SEARCH;
            end
            default: next_s.lock = clock_manager_pkg::LOCK_SEARCH;
         endcase
      end else begin
         if (s.pos != '1) next_s.pos = meas;
         if (eff_lvl && s.hi_cnt != '1) next_s.hi_cnt = s.hi_cnt + 12'h001;
      end
      locked = (s.lock == clock_manager_pkg::LOCK_DONE);

      // Phase offset in reference cycles, deskew delay added
      p    = s.per;
      half = s.ctrl.duty_correct ? (p >> 1) : s.hi;
      prod = s.phase_cur * $signed({1'b0, p});
      if (s.ctrl.phase_shift_mode == clock_manager_pkg::SHIFT_DIRECT)
         sh = 16'(s.phase_cur);
      else
         sh = prod[23:`PHASE_FRAC_BITS];
      if (!s.ctrl.source_sync) sh = sh + `DESKEW_SYS_CYC;
      if (sh < 0) sh = sh + $signed({4'h0, p});
      shm = (p == '0) ? '0 : 16'(sh) % {4'h0, p};
      ps  = wrap({1'b0, s.pos} + {1'b0, p} - shm[12:0], p);
      next_s.outs.phase_0_out   = locked && ps < {1'b0, half};
      next_s.outs.phase_90_out  =
         locked && wrap(ps + {1'b0, p} - {3'h0, p[11:2]}, p) < {1'b0, half};
      next_s.outs.phase_180_out =
         locked && wrap(ps + {1'b0, p} - {2'h0, p[11:1]}, p) < {1'b0, half};
      next_s.outs.phase_270_out = locked &&
         wrap(ps + {2'h0, p[11:1]} - {3'h0, p[11:2]}, p) < {1'b0, half};

      // Divided clock: period N/2 times the effective period
      dv_per = (18'(s.ratio.divided_clock_ratio) * 18'(p)) >> 1;
      if (s.ctrl.loop_high && s.ratio.divided_clock_ratio[0])
         dv_hi = (18'(s.ratio.divided_clock_ratio >> 1) * 18'(p)) >> 1;
      else
         dv_hi = dv_per >> 1;
      dv_inc = {1'b0, s.dv} + 18'h00001;
      next_s.dv = (!locked || dv_inc >= dv_per) ? '0 : dv_inc[16:0];
      next_s.outs.divided_clock_out = locked && {1'b0, s.dv} < dv_hi;

      // Synthesized clock by accumulating 2M against 2*P*D
      pd     = 18'(p) * 18'(s.ratio.synth_divisor);
      fx_sum = {1'b0, s.fx} + 19'({s.ratio.synth_multiplier, 1'b0});
      if (fx_sum >= {pd, 1'b0}) fx_sum = fx_sum - {pd, 1'b0};
      next_s.fx = locked ? fx_sum[17:0] : '0;
      hint_cyc = 16'(s.input_period_hint >> `HINT_FRAC_BITS) / 16'(`CLK_PERIOD_NS);
      if (s.ctrl.input_halve_enable) hint_cyc = hint_cyc << 1;
      hint_ok  = (s.input_period_hint == '0) ||
                 ((hint_cyc <= {4'h0, p + `HINT_TOL}) &&
                  (hint_cyc + {4'h0, `HINT_TOL} >= {4'h0, p}));
      synth_ok = locked && hint_ok && (s.ctrl.synth_high ?
                 (p <= `SYNTH_HI_MAX_PER) : (p >= `SYNTH_LO_MIN_PER));
      next_s.outs.synth_clock_out          = synth_ok && {1'b0, s.fx} < {1'b0, pd};
      next_s.outs.synth_clock_out_inverted = synth_ok && {1'b0, s.fx} >= {1'b0, pd};

      // Variable steps only in variable or direct modes
      var_mode = s.ctrl.phase_shift_mode == clock_manager_pkg::SHIFT_VAR_POS ||
                 s.ctrl.phase_shift_mode == clock_manager_pkg::SHIFT_VAR_CTR ||
                 s.ctrl.phase_shift_mode == clock_manager_pkg::SHIFT_DIRECT;
      if (locked && var_mode && shift_step_enable_i) begin
         next_s.phase_cur = clamp_phase(s.ctrl.phase_shift_mode, s.ctrl.max_range,
            shift_direction_i ? s.phase_cur + 11'sh001 : s.phase_cur - 11'sh001);
      end

      if (bus_i.wr_en) begin
         case (bus_i.addr)
            `ADDR_CTRL: begin
               next_s.ctrl = w_ctrl;
               if (w_ctrl.phase_shift_mode > clock_manager_pkg::SHIFT_DIRECT)
                  next_s.ctrl.phase_shift_mode = s.ctrl.phase_shift_mode;
               next_s.phase_cur =
                  (next_s.ctrl.phase_shift_mode == clock_manager_pkg::SHIFT_DIRECT) ?
                  `RST_PHASE : clamp_phase(next_s.ctrl.phase_shift_mode,
                                           w_ctrl.max_range, s.phase_cfg);
            end
            `ADDR_RATIO: begin
               // Illegal ratios are dropped rather than rounded
               if (w_ratio.divided_clock_ratio >= `HALVES_MIN &&
                   w_ratio.divided_clock_ratio <= `HALVES_MAX &&
                   (w_ratio.divided_clock_ratio <= `HALVES_INT_FROM ||
                    !w_ratio.divided_clock_ratio[0]))
                  next_s.ratio.divided_clock_ratio = w_ratio.divided_clock_ratio;
               if (w_ratio.synth_multiplier >= `MULT_MIN &&
                   w_ratio.synth_multiplier <= `MULT_MAX &&
                   w_ratio.synth_divisor >= `DIVISOR_MIN &&
                   w_ratio.synth_divisor <= `DIVISOR_MAX) begin
                  next_s.ratio.synth_multiplier = w_ratio.synth_multiplier;
                  next_s.ratio.synth_divisor    = w_ratio.synth_divisor;
               end
            end
            `ADDR_HINT: next_s.input_period_hint = bus_i.wr_data[`HINT_W-1:0];
            `ADDR_PHASE: begin
               next_s.phase_cfg = clamp_phase(s.ctrl.phase_shift_mode, s.ctrl.max_range,
                                              bus_i.wr_data[`PHASE_W-1:0]);
               if (s.ctrl.phase_shift_mode != clock_manager_pkg::SHIFT_DIRECT)
                  next_s.phase_cur = next_s.phase_cfg;
            end
            // One setting serves both loop ranges
            `ADDR_JITTER: next_s.jitter_filter_setting =
               bus_i.wr_data[`JITTER_W-1:0];
            default: ;
         endcase
      end

      if (bus_i.rd_en) begin
         case (bus_i.addr)
            `ADDR_CTRL:   next_s.rdata = 32'(s.ctrl);
            `ADDR_RATIO:  next_s.rdata = 32'(s.ratio);
            `ADDR_HINT:   next_s.rdata = 32'(s.input_period_hint);
            `ADDR_PHASE:  next_s.rdata = 32'($unsigned(s.phase_cfg));
            `ADDR_JITTER: next_s.rdata = 32'(s.jitter_filter_setting);
            `ADDR_STATUS: next_s.rdata = {4'h0, s.per, 1'b0, $unsigned(s.phase_cur),
                                          1'b0, synth_ok, ~hint_ok, locked};
            default:      next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s <= '0;
         s.ctrl.duty_correct <= 1'b1;
         s.ctrl.lock_wait_cycle <= `RST_LOCK_CYCLE;
         s.ratio.divided_clock_ratio <= `RST_HALVES;
         s.ratio.synth_multiplier <= `RST_MULT;
         s.ratio.synth_divisor <= `RST_DIVISOR;
         s.input_period_hint <= `RST_HINT;
         s.phase_cfg <= `RST_PHASE;
         s.phase_cur <= `RST_PHASE;
         s.jitter_filter_setting <= `RST_JITTER;
         s.lock <= clock_manager_pkg::LOCK_SEARCH;
      end else if (clk_en_i) begin
         s <= next_s;
      end
   end

   assign rd_data_o = s.rdata;
   assign locked_o  = (s.lock == clock_manager_pkg::LOCK_DONE);
   assign clocks_o  = s.outs;
   assign startup_stall_o = s.ctrl.startup_wait &&
                            startup_cycle_i == s.ctrl.lock_wait_cycle &&
                            s.lock != clock_manager_pkg::LOCK_DONE;

endmodule : clock_manager

//--- sim/clock_manager_asserts.sv
// Checker of clock manager ports: lock, clock outputs, read port.
// Assumes a bind into clock_manager on its one reference clock.
`timescale 1ns/1ps
module clock_manager_asserts (
   input wire logic                        ref_clk_i,
   input wire logic                        reset_n_i,
   input wire logic                        clk_en_i,
   input wire clock_manager_pkg::bus_req_t bus_i,
   input wire logic [31:0]                 rd_data_o,
   input wire logic                        startup_stall_o,
   input wire logic                        locked_o,
   input wire clock_manager_pkg::clk_out_t clocks_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   logic [7:0] age;
   // Lock needs nine source periods of two cycles at least
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) age <= 8'h00;
      else if (age != 8'hff) age <= age + 8'h01;
   end
   property p_stall; locked_o |-> !startup_stall_o; endproperty
   a_stall: assert property (p_stall) else $error("stall while locked");
   property p_early; locked_o |-> age >= 8'h12; endproperty
   a_early: assert property (p_early) else $error("lock too early");
   property p_quiet; !locked_o [*2] |-> clocks_o == 7'h00; endproperty
   a_quiet: assert property (p_quiet) else $error("clock while unlocked");
   property p_dcc0; clocks_o.phase_0_out |-> !clocks_o.phase_180_out; endproperty
   a_dcc0: assert property (p_dcc0) else $error("phase 0 and 180 overlap");
   property p_dcc90; clocks_o.phase_90_out |-> !clocks_o.phase_270_out; endproperty
   a_dcc90: assert property (p_dcc90) else $error("phase 90 and 270 overlap");
   property p_synth;
      clocks_o.synth_clock_out |-> !clocks_o.synth_clock_out_inverted;
   endproperty
   a_synth: assert property (p_synth) else $error("synth copies overlap");
   property p_idle; clk_en_i && !bus_i.rd_en |=> rd_data_o == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data without read");
   property p_hole; clk_en_i && bus_i.rd_en && bus_i.addr == 8'h18 |=> rd_data_o == 32'h0;
   endproperty
   a_hole: assert property (p_hole) else $error("unmapped read not zero");
   property p_freeze; !clk_en_i |=> $stable(locked_o) && $stable(clocks_o); endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
   c_lock: cover property ($rose(locked_o));
   c_stall: cover property (startup_stall_o);
   c_synth: cover property (locked_o && clocks_o.synth_clock_out);
endmodule : clock_manager_asserts

bind clock_manager clock_manager_asserts chk_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
   .clk_en_i(clk_en_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
   .startup_stall_o(startup_stall_o), .locked_o(locked_o), .clocks_o(clocks_o));

//--- sim/fabric_model.sv
// Far side: source clock generator and configuration startup sequencer.
// Assumes one reference clock; the source toggles every half_i cycles.
`timescale 1ns/1ps
module fabric_model (
   input  wire logic       ref_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       run_i,
   input  wire logic [7:0] half_i,
   input  wire logic       go_i,
   input  wire logic       stall_i,
   output logic            source_clock_o,
   output logic [2:0]      cycle_o
);
   logic [7:0] cnt;
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt <= 8'h00;
         source_clock_o <= 1'b0;
         cycle_o <= 3'h0;
      end else begin
         // Stands low when stopped, so no stale edge reaches the loop
         if (!run_i || cnt == half_i - 8'h01) cnt <= 8'h00;
         else cnt <= cnt + 8'h01;
         if (!run_i) source_clock_o <= 1'b0;
         else if (cnt == half_i - 8'h01) source_clock_o <= ~source_clock_o;
         if (go_i && !stall_i && cycle_o != 3'h7) cycle_o <= cycle_o + 3'h1;
      end
   end
endmodule : fabric_model

//--- sim/clock_manager_configuration_tb.sv
// Bench of the clock manager: registers, startup hold, lock and clock shapes.
// Assumes fabric_model as source and sequencer, checker bound to the design.
`timescale 1ns/1ps
module clock_manager_configuration_tb;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } row_t;
   logic                        ref_clk_i = 1'b0;
   logic                        reset_n_i = 1'b0;
   logic                        clk_en = 1'b1;
   clock_manager_pkg::bus_req_t bus = '0;
   logic [31:0]                 rd_data;
   logic                        src;
   logic                        step_en = 1'b0;
   logic                        step_dir = 1'b0;
   logic [2:0]                  cycle;
   logic                        stall;
   logic                        locked;
   clock_manager_pkg::clk_out_t clocks;
   logic                        run = 1'b0;
   logic [7:0]                  half = 8'h0a;
   logic                        go = 1'b0;
   int                          n_errors = 0;
   int                          total_checks = 0;
   row_t rows [21] = '{
      '{8'h00, 32'h1482, 32'h1482}, '{8'h00, 32'h148a, 32'h1482}, '{8'h0c, 32'h0c8, 32'h07f},
      '{8'h0c, 32'h738, 32'h781}, '{8'h00, 32'h1582, 32'h1582}, '{8'h0c, 32'h0c8, 32'h0c8},
      '{8'h00, 32'h1484, 32'h1484}, '{8'h0c, 32'h738, 32'h000}, '{8'h00, 32'h1486, 32'h1486},
      '{8'h00, 32'h1488, 32'h1488}, '{8'h0c, 32'h3ff, 32'h3ff}, '{8'h00, 32'h1490, 32'h1490},
      '{8'h04, 32'h10402, 32'h10404}, '{8'h04, 32'h10411, 32'h10404},
      '{8'h04, 32'h10403, 32'h10403}, '{8'h04, 32'h10120, 32'h10420},
      '{8'h04, 32'h210220, 32'h10420}, '{8'h04, 32'h202020, 32'h202020},
      '{8'h08, 32'h1400, 32'h1400}, '{8'h10, 32'hf0f0, 32'hf0f0}, '{8'h18, 32'h1234, 32'h0}};

   always #5 ref_clk_i = ~ref_clk_i;

   clock_manager dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
      .bus_i(bus), .rd_data_o(rd_data), .source_clock_in_i(src), .shift_step_enable_i(step_en),
      .shift_direction_i(step_dir), .startup_cycle_i(cycle), .startup_stall_o(stall),
      .locked_o(locked), .clocks_o(clocks));
   fabric_model fab_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .run_i(run),
      .half_i(half), .go_i(go), .stall_i(stall), .source_clock_o(src), .cycle_o(cycle));

   task automatic final_report;
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      bus.addr <= a;
      bus.wr_data <= d;
      bus.wr_en <= 1'b1;
      @(posedge ref_clk_i);
      bus.wr_en <= 1'b0;
   endtask : wr

   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge ref_clk_i);
      bus.addr <= a;
      bus.rd_en <= 1'b1;
      @(posedge ref_clk_i);
      bus.rd_en <= 1'b0;
      @(negedge ref_clk_i);
      check(rd_data & m, e);
   endtask : rdm

   task automatic wait_lock(input logic v);
      int t;
      t = 0;
      while (locked !== v && t < 2000) begin
         @(negedge ref_clk_i);
         t++;
      end
      check({31'h0, locked}, {31'h0, v});
   endtask : wait_lock

   // Period and high time of one output, in reference cycles
   task automatic meas(input int idx, output int per, output int high);
      int t;
      t = 0;
      high = 0;
      while (clocks[idx] !== 1'b0 && t < 500) begin @(negedge ref_clk_i); t++; end
      while (clocks[idx] !== 1'b1 && t < 500) begin @(negedge ref_clk_i); t++; end
      while (clocks[idx] === 1'b1 && t < 500) begin @(negedge ref_clk_i); t++; high++; end
      per = high;
      while (clocks[idx] === 1'b0 && t < 500) begin @(negedge ref_clk_i); t++; per++; end
   endtask : meas

   // First cycle after a change may be partial, so the second counts
   task automatic shape(input int idx, input logic [31:0] exp);
      int per;
      int high;
      meas(idx, per, high);
      meas(idx, per, high);
      check(32'(per * 65536 + high), exp);
   endtask : shape

   initial begin
      #400000;
      n_errors++;
      final_report();
   end

   initial begin
      repeat (2) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rdm(rows[i].a, 32'hffffffff, rows[i].e);
      end
      @(posedge ref_clk_i);
      reset_n_i <= 1'b0;
      @(negedge ref_clk_i);
      check({24'h0, locked, clocks}, 32'h0);
      repeat (2) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      rdm(8'h00, 32'hffffffff, 32'h00001480);
      rdm(8'h04, 32'hffffffff, 32'h00010404);
      rdm(8'h08, 32'hffffffff, 32'h00000000);
      rdm(8'h0c, 32'hffffffff, 32'h00000000);
      rdm(8'h10, 32'hffffffff, 32'h0000f0f0);
      rdm(8'h14, 32'h00000001, 32'h00000000);
      wr(8'h00, 32'h00001680);
      wr(8'h04, 32'h00010204);
      @(posedge ref_clk_i);
      go <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      check({28'h0, stall, cycle}, 32'hd);
      @(posedge ref_clk_i);
      run <= 1'b1;
      wait_lock(1'b1);
      repeat (4) @(negedge ref_clk_i);
      check({28'h0, stall, cycle}, 32'h7);
      shape(6, 32'h0014000a);
      shape(5, 32'h0014000a);
      shape(2, 32'h00280014);
      shape(1, 32'h000a0005);
      shape(0, 32'h000a0005);
      shape(4, 32'h0014000a);
      shape(3, 32'h0014000a);
      rdm(8'h14, 32'h0fff0001, 32'h00140001);
      wr(8'h04, 32'h00010203);
      shape(2, 32'h001e000f);
      wr(8'h00, 32'h00001484);
      wr(8'h0c, 32'h00000000);
      wait_lock(1'b1);
      @(posedge ref_clk_i);
      step_dir <= 1'b1;
      step_en <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      step_dir <= 1'b0;
      @(posedge ref_clk_i);
      step_en <= 1'b0;
      rdm(8'h14, 32'h00007ff0, 32'h00000020);
      @(posedge ref_clk_i);
      clk_en <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      clk_en <= 1'b1;
      wr(8'h00, 32'h00001481);
      wait_lock(1'b0);
      wait_lock(1'b1);
      shape(6, 32'h00280014);
      rdm(8'h14, 32'h0fff0007, 32'h00280005);
      wr(8'h08, 32'h0000c800);
      rdm(8'h14, 32'h00000007, 32'h00000005);
      wr(8'h08, 32'h00006400);
      rdm(8'h14, 32'h00000007, 32'h00000003);
      wr(8'h08, 32'h00000000);
      wr(8'h00, 32'h000014a1);
      rdm(8'h14, 32'h00000007, 32'h00000001);
      wr(8'h00, 32'h000014c1);
      wait_lock(1'b0);
      wr(8'h00, 32'h000014c0);
      half <= 8'h04;
      wait_lock(1'b1);
      shape(2, 32'h000c0004);
      final_report();
   end
endmodule : clock_manager_configuration_tb
